// file: src/excitation_bias_config_regs.sv
// AXI4-Lite register slice for excitation current and sensor bias control
`timescale 1ns/1ps
`default_nettype none
`include "bias_cfg_defs.svh"
module excitation_bias_config_regs
(
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           power_down,
  input  wire logic [7:0]                     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [7:0]                     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output bias_cfg_pkg::excitation_ctrl_t      excitation_ctrl,
  output bias_cfg_pkg::bias_ctrl_t            bias_ctrl
);

  logic [7:0]  mag_q;
  logic [7:0]  route_q;
  logic [7:0]  bias_q;
  logic        aw_held_q;
  logic [7:0]  awaddr_q;
  logic        w_held_q;
  logic [31:0] wdata_q;
  logic        wstrb0_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        pd_meta_q;
  logic        pd_sync_q;

  // Write channel capture and decode
  wire        aw_take   = s_axi_awvalid && s_axi_awready;
  wire        w_take    = s_axi_wvalid && s_axi_wready;
  wire        aw_have   = aw_held_q || aw_take;
  wire        w_have    = w_held_q || w_take;
  wire [7:0]  wr_addr   = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data   = w_held_q ? wdata_q : s_axi_wdata;
  wire        wr_lane0  = w_held_q ? wstrb0_q : s_axi_wstrb[0];
  wire        wr_fire   = aw_have && w_have && !bvalid_q;
  wire [5:0]  wr_index  = wr_addr[7:2];
  wire        wr_word   = (wr_addr[1:0] == 2'b00);
  wire        wr_mag    = wr_word && (wr_index == 6'(`MAG_INDEX));
  wire        wr_route  = wr_word && (wr_index == 6'(`ROUTE_INDEX));
  wire        wr_bias   = wr_word && (wr_index == 6'(`BIAS_INDEX));
  wire        wr_hit    = wr_mag || wr_route || wr_bias;
  wire        wr_en     = wr_fire && wr_lane0;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // Read decode, index is byte address divided by four
  wire [5:0]  rd_index  = s_axi_araddr[7:2];
  wire        rd_word   = (s_axi_araddr[1:0] == 2'b00);
  wire        rd_mag    = rd_word && (rd_index == 6'(`MAG_INDEX));
  wire        rd_route  = rd_word && (rd_index == 6'(`ROUTE_INDEX));
  wire        rd_bias   = rd_word && (rd_index == 6'(`BIAS_INDEX));
  wire        rd_hit    = rd_mag || rd_route || rd_bias;
  wire        rd_take   = s_axi_arvalid && s_axi_arready;
  wire [7:0]  rd_byte   = rd_mag   ? (mag_q & `MAG_WRITE_MASK) : // R14
                          rd_route ? route_q :
                          rd_bias  ? bias_q : 8'h00;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Address and data holding when one arrives before the other
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb0_q  <= 1'b0;
    end
    else
    begin
      if (aw_take)
        awaddr_q <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      aw_held_q <= aw_have && !wr_fire;
      w_held_q  <= w_have && !wr_fire;
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `AXI_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mag_q   <= `MAG_RESET; // R13
      route_q <= `ROUTE_RESET; // R6
      bias_q  <= `BIAS_RESET; // R12
    end
    else if (wr_en)
    begin
      if (wr_mag)
        mag_q <= wr_data[7:0] & `MAG_WRITE_MASK; // R14
      if (wr_route)
        route_q <= wr_data[7:0]; // R6
      if (wr_bias)
        bias_q <= wr_data[7:0]; // R11
    end
  end

  // Read response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `AXI_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // Power-down pin synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pd_meta_q <= 1'b0;
      pd_sync_q <= 1'b0;
    end
    else
    begin
      pd_meta_q <= power_down;
      pd_sync_q <= pd_meta_q;
    end
  end

  // Analog control outputs
  wire second_connected = (route_q[7:4] < `ROUTE_DISC); // R4
  wire first_connected  = (route_q[3:0] < `ROUTE_DISC); // R5
  wire rail_on    = mag_q[`RAIL_BIT]; // R1
  wire switch_on  = mag_q[`SWITCH_BIT] && !pd_sync_q; // R2
  wire current_on = (mag_q[3:0] != 4'h0); // R3
  wire bias_on    = |bias_q[6:0]; // R8
  // One driver per output struct
  assign excitation_ctrl = {rail_on, switch_on, mag_q[3:0], route_q[3:0], route_q[7:4],
                            first_connected && current_on, second_connected && current_on};
  assign bias_ctrl       = {bias_on, bias_q[7], bias_q[6], bias_q[5:0]}; // R7 R9 R10

endmodule : excitation_bias_config_regs
`default_nettype wire

// file: inc/bias_cfg_defs.svh
// Register offsets, field positions and reset values of the excitation and bias slice
// Overview of operation
// R1: Bit 7 of the magnitude register turns the amplifier rail monitor on when 1 and resets to off.
// R2: Bit 6 of the magnitude register closes the low-side switch when 1, resets open, and is forced open in power-down.
// R3: Bits 3:0 of the magnitude register set one shared current code for both sources, 0000 off at reset.
// R4: Bits 7:4 of the routing register route the second source, 1100 common input, 1101-1111 disconnected, reset all ones.
// R5: Bits 3:0 of the routing register route the first source with the same table and reset disconnected.
// R6: The routing register sits at address 07h and resets to ffh.
// R7: Bit 7 of the bias register selects the bias level, 0 mid-supply at reset, 1 one twelfth.
// R8: The bias generator is enabled only while at least one connection bit is set.
// R9: Bit 6 of the bias register connects bias to the common input and resets disconnected.
// R10: Bits 5:0 of the bias register connect bias to inputs 5 to 0 and reset to zero.
// R11: Any combination of bias connection bits may be set at once.
// R12: The bias register sits at address 08h and resets to 00h.
// R13: The magnitude register sits at address 06h and resets to 00h.
// R14: Bits 5:4 of the magnitude register read as zero and ignore writes.
`ifndef BIAS_CFG_DEFS_SVH
`define BIAS_CFG_DEFS_SVH
`define MAG_INDEX      8'h06
`define ROUTE_INDEX    8'h07
`define BIAS_INDEX     8'h08
`define MAG_RESET      8'h00
`define ROUTE_RESET    8'hff
`define BIAS_RESET     8'h00
`define MAG_WRITE_MASK 8'hcf
`define RAIL_BIT       7
`define SWITCH_BIT     6
`define ROUTE_DISC     4'hd
`define AXI_OKAY       2'b00
`define AXI_SLVERR     2'b10
`endif

// file: inc/bias_cfg_pkg.sv
// Types for the excitation and bias configuration slice
package bias_cfg_pkg;
  typedef struct packed {
    logic       rail_monitor_enable;
    logic       low_side_switch_close;
    logic [3:0] excitation_magnitude;
    logic [3:0] first_source_route;
    logic [3:0] second_source_route;
    logic       first_source_connected;
    logic       second_source_connected;
  } excitation_ctrl_t;
  typedef struct packed {
    logic       bias_enable;
    logic       bias_level_select;
    logic       bias_to_common_input;
    logic [5:0] bias_to_input;
  } bias_ctrl_t;
endpackage : bias_cfg_pkg

// file: verification/excitation_bias_monitor.sv
// Assertions on the excitation and bias register slice
`timescale 1ns/1ps
`default_nettype none
module excitation_bias_monitor
(
  input wire logic                           aclk,
  input wire logic                           aresetn,
  input wire logic                           power_down,
  input wire logic                           s_axi_bvalid,
  input wire logic                           s_axi_bready,
  input wire logic                           s_axi_arvalid,
  input wire logic                           s_axi_arready,
  input wire logic [31:0]                    s_axi_rdata,
  input wire logic                           s_axi_rvalid,
  input wire logic                           s_axi_rready,
  input wire bias_cfg_pkg::excitation_ctrl_t excitation_ctrl,
  input wire bias_cfg_pkg::bias_ctrl_t       bias_ctrl
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Register reset values reach the outputs
  a_reset_values: assert property (disable iff (1'b0) !aresetn |=>
    excitation_ctrl[15:2] == 14'h00ff && bias_ctrl == 9'h000) else $error("bad reset value");
  // Bias generator on only with a connection
  a_bias_enable: assert property (bias_ctrl.bias_enable == (|bias_ctrl[6:0]))
    else $error("bias enable wrong");
  // Power-down opens the switch within two edges
  a_switch_opens: assert property (power_down [*3] |->
    !excitation_ctrl.low_side_switch_close) else $error("switch closed in power-down");
  // Upper read data stays zero
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data set");
  // Read answered in the next cycle
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  // Responses released once taken
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response held");
  a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held");
  // Source connected only with a live route and current
  a_first_conn: assert property (excitation_ctrl.first_source_connected ==
    (excitation_ctrl.first_source_route < 4'hd && excitation_ctrl.excitation_magnitude != 4'h0))
    else $error("first source connection wrong");
  a_second_conn: assert property (excitation_ctrl.second_source_connected ==
    (excitation_ctrl.second_source_route < 4'hd && excitation_ctrl.excitation_magnitude != 4'h0))
    else $error("second source connection wrong");
endmodule : excitation_bias_monitor
bind excitation_bias_config_regs excitation_bias_monitor i_excitation_bias_monitor (.*);
`default_nettype wire

// file: verification/tb_top.sv
// Register-level testbench for the excitation and bias slice
`timescale 1ns/1ps
`default_nettype none
`include "bias_cfg_defs.svh"
module tb_top;
  localparam logic [7:0] addr_mag = 8'(`MAG_INDEX * 4);
  localparam logic [7:0] addr_route = 8'(`ROUTE_INDEX * 4);
  localparam logic [7:0] addr_bias = 8'(`BIAS_INDEX * 4);
  logic                           aclk = 1'b0;
  logic                           aresetn, power_down, s_axi_awvalid, s_axi_wvalid;
  logic                           s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready;
  logic                           s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]                     s_axi_awaddr, s_axi_araddr;
  logic [31:0]                    s_axi_wdata, s_axi_rdata, d;
  logic [3:0]                     s_axi_wstrb;
  logic [1:0]                     s_axi_bresp, s_axi_rresp, r;
  bias_cfg_pkg::excitation_ctrl_t excitation_ctrl;
  bias_cfg_pkg::bias_ctrl_t       bias_ctrl;
  logic [7:0]                     tab [5] = '{8'h80, 8'h40, 8'h3f, 8'h15, 8'h00};
  int                             miscompares = 0;
  int                             num_checks = 0;
  excitation_bias_config_regs i_excitation_bias_config_regs (.*);
  // Free-running clock
  always #5 aclk = ~aclk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, s, e);
    end
  endtask : chk
  // Write with address and data offered together
  task wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw)
    begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
  endtask : wr
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask : rd
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
    chk(32'(r), 32'(`AXI_OKAY));
  endtask : rc
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  // Watchdog against a hung handshake
  initial
  begin
    repeat (4000) @(posedge aclk);
    miscompares++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    {aresetn, power_down, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(addr_mag, 32'h0);
    rc(addr_route, 32'hff);
    rc(addr_bias, 32'h0);
    wr(addr_mag, 8'hff, 4'hf);
    rc(addr_mag, 32'hcf);
    chk(32'(excitation_ctrl[15:14]), 32'h3);
    power_down <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(excitation_ctrl.low_side_switch_close), 32'h0);
    power_down <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'(excitation_ctrl.low_side_switch_close), 32'h1);
    // Magnitude codes 0 to 6, monitor and switch cleared
    for (int i = 0; i < 7; i++)
    begin
      wr(addr_mag, 8'(i), 4'h1);
      chk(32'(excitation_ctrl[15:10]), 32'(i));
    end
    wr(addr_route, 8'hc5, 4'hf);
    chk(32'(excitation_ctrl[9:0]), 32'h173);
    wr(addr_route, 8'hd6, 4'hf);
    chk(32'(excitation_ctrl[9:0]), 32'h1b6);
    // Bias level and connection patterns
    foreach (tab[i])
    begin
      wr(addr_bias, tab[i], 4'hf);
      rc(addr_bias, {24'h0, tab[i]});
      chk(32'(bias_ctrl), 32'({|tab[i][6:0], tab[i]}));
    end
    wr(addr_bias, 8'h55, 4'h0);
    rc(addr_bias, 32'h0);
    wr(8'h24, 8'h01, 4'hf);
    chk(32'(r), 32'(`AXI_SLVERR));
    rd(8'h24);
    chk(d, 32'h0);
    chk(32'(r), 32'(`AXI_SLVERR));
    // Reset in mid-run restores the routing register
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(addr_route, 32'hff);
    rc(addr_mag, 32'h0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
